// File: src/scpr_top.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: Parallel port works when serial select low; word mode 0, byte mode 1.
// RULE_02: Host pulses conversion start low then high; rising edge starts conversion.
// RULE_03: Conversion timed internally, lasts 3 us, then busy goes low.
// RULE_04: Busy falling edge returns the sampling stages from hold to track.
// RULE_05: Each start input drives one pair: 1-2, 3-4, 5-6; results stored.
// RULE_06: All three starts together convert all six channels simultaneously.
// RULE_07: Data lines driven only while chip select and read both low.
// RULE_08: Host may tie chip select low; reads only after busy falls.
// RULE_09: Word mode needs one read per converted channel.
// RULE_10: Results appear in ascending channel order on successive reads.
// RULE_11: 14-bit variant: result on bits 13..0, bits 15..14 zero.
// RULE_12: 12-bit variant: result on bits 11..0, bits 15..12 zero.
// RULE_13: Host never starts a pair while busy is high.
// RULE_14: Host should avoid starting during reads and read after conversion.
// RULE_15: Byte mode gives each result in two reads on lines 15..8.
// RULE_16: Byte order select low gives low byte first, high gives high first.
// RULE_17: Byte mode with all six converted takes twelve reads.
// RULE_18: Busy goes high after a start rising edge while converting.
// RULE_19: Results are two's complement.
// RULE_20: Pointer advances after each read; resets to lowest channel on completion.
module scpr_top #(
    parameter int unsigned RES_BITS = scpr_pkg::DEF_RES_BITS
) (
    // Clock, reset and enable
    input  wire logic                clk_sys,
    input  wire logic                rstn,
    input  wire logic                ce,
    // Conversion start pins, one per pair
    input  wire logic [2:0]          pair_convert_start,
    // Parallel bus pins
    input  wire logic                cs_n,
    input  wire logic                rd_n,
    input  wire logic                serial_parallel_select,
    input  wire logic                word_byte_select,
    input  wire logic                high_byte_first,
    // Data lines, enables active low per byte lane
    output logic [15:0]              db_out,
    output logic [1:0]               db_oe_n,
    // Converter core side
    input  wire logic [5:0][15:0]    adc_code,
    output logic                     busy,
    output logic [2:0]               hold_pair
);

    // ****************************************************************
    // Constants and helpers
    // ****************************************************************
    localparam logic [15:0] RES_MASK = 16'((32'h1 << RES_BITS) - 1);
    localparam logic [15:0] RES_MSB  = 16'(32'h1 << (RES_BITS - 1));

    // Lowest channel set in a mask
    function automatic logic [2:0] first_ch(input logic [5:0] m);
        logic [2:0] r;
        r = scpr_pkg::PTR_RST;
        for (int i = 5; i >= 0; i--)
            if (m[i])
                r = 3'(i);
        return r;
    endfunction

    // Next channel above p in the mask, wrapping to the lowest
    function automatic logic [2:0] next_ch(input logic [5:0] m, input logic [2:0] p);
        logic [2:0] r;
        r = first_ch(m);
        for (int i = 5; i >= 0; i--)
            if (m[i] && (3'(i) > p))
                r = 3'(i);
        return r;
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [7:0] pins_w;
    logic [7:0] lvl_w;

    assign pins_w = {high_byte_first, word_byte_select, serial_parallel_select,
                     rd_n, cs_n, pair_convert_start};

    scpr_sync #(
        .W   (scpr_pkg::PIN_W),
        .RST (scpr_pkg::PIN_RST)
    ) u_sync (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .ce      (ce),
        .pin_in  (pins_w),
        .level   (lvl_w)
    );

    logic [2:0] conv_lvl_w;
    logic       cs_lvl_w;
    logic       rd_lvl_w;
    logic       sps_lvl_w;
    logic       wb_lvl_w;
    logic       hbf_lvl_w;

    assign conv_lvl_w = lvl_w[scpr_pkg::PIN_CONV +: 3];
    assign cs_lvl_w   = lvl_w[scpr_pkg::PIN_CS];
    assign rd_lvl_w   = lvl_w[scpr_pkg::PIN_RD];
    assign sps_lvl_w  = lvl_w[scpr_pkg::PIN_SPS];
    assign wb_lvl_w   = lvl_w[scpr_pkg::PIN_WB];
    assign hbf_lvl_w  = lvl_w[scpr_pkg::PIN_HBF];

    // ****************************************************************
    // Conversion start and pair timers
    // ****************************************************************
    logic [2:0] conv_q_r;
    logic [2:0] rise_w;
    logic [2:0] start_w;
    logic [2:0] active_w;
    logic       any_act_w;
    logic       busy_r;
    logic       busy_fall_w;

    // Rising edge after a low phase is a complete start pulse
    assign rise_w      = conv_lvl_w & ~conv_q_r;                 // [RULE_02]
    // Each input starts its own pair; tied inputs start all pairs at once
    assign start_w     = rise_w & ~active_w;                     // [RULE_05] [RULE_06]
    assign any_act_w   = |active_w;
    assign busy_fall_w = busy_r & ~any_act_w;

    genvar gp;
    generate
        for (gp = 0; gp < scpr_pkg::NPAIR; gp++)
        begin : g_pair
            scpr_pair u_pair (
                .clk_sys (clk_sys),
                .rstn    (rstn),
                .ce      (ce),
                .start   (start_w[gp]),
                .active  (active_w[gp])
            );
        end
    endgenerate

    // ****************************************************************
    // Busy, hold and captured results
    // ****************************************************************
    logic [2:0]  hold_r;
    logic [2:0]  pend_r;
    logic [2:0]  pend_nxt;
    logic [5:0]  pend_ch_w;
    logic [5:0]  mask_r;
    logic [15:0] res_r [6];

    assign pend_nxt  = (busy_fall_w ? 3'h0 : pend_r) | start_w;
    assign pend_ch_w = {{2{pend_r[2]}}, {2{pend_r[1]}}, {2{pend_r[0]}}};

    // Busy follows the pair timers; hold drops for every pair when busy falls.
    // A start landing in the completion cycle still takes its pair into hold.
    // Edge memory resets to the idle-high level so reset never fakes a start.
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            conv_q_r <= scpr_pkg::CONV_IDLE;
            busy_r   <= 1'b0;
            hold_r   <= 3'h0;
            pend_r   <= 3'h0;
            mask_r   <= 6'h00;
        end
        else if (ce)
        begin
            conv_q_r <= conv_lvl_w;                              // [RULE_02]
            busy_r <= any_act_w;                                 // [RULE_18] [RULE_03]
            hold_r <= (busy_fall_w ? 3'h0 : hold_r) | start_w;   // [RULE_04]
            pend_r <= pend_nxt;
            if (busy_fall_w)
                mask_r <= pend_ch_w;
        end
    end

    // Offset-binary core codes become two's complement, right aligned, upper bits zero
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < scpr_pkg::NCH; i++)
                res_r[i] <= scpr_pkg::DATA_RST;
        end
        else if (ce && busy_fall_w)
        begin
            for (int i = 0; i < scpr_pkg::NCH; i++)
                if (pend_ch_w[i])
                    res_r[i] <= (adc_code[i] ^ RES_MSB) & RES_MASK; // [RULE_19] [RULE_11] [RULE_12]
        end
    end

    // ****************************************************************
    // Parallel readout
    // ****************************************************************
    logic        acc_w;
    logic        acc_q_r;
    logic        rd_end_w;
    logic [2:0]  ptr_r;
    logic [2:0]  ptr_nxt;
    logic        phase_r;
    logic        phase_nxt;
    logic [15:0] cur_w;
    logic        show_high_w;
    logic [15:0] db_nxt;
    logic [1:0]  oe_nxt;
    logic [15:0] db_r;
    logic [1:0]  oe_r;

    // Drive only with both strobes low and the parallel port selected
    assign acc_w       = ~cs_lvl_w & ~rd_lvl_w & (sps_lvl_w == scpr_pkg::SPS_PARALLEL); // [RULE_07]
    assign rd_end_w    = acc_q_r & ~acc_w;
    assign cur_w       = res_r[ptr_r];
    // First byte follows the order pin, second byte is the other half
    assign show_high_w = hbf_lvl_w ^ phase_r;                    // [RULE_16]
    assign db_nxt      = (wb_lvl_w == scpr_pkg::WB_WORD) ? cur_w :
                         {(show_high_w ? cur_w[15:8] : cur_w[7:0]), 8'h00}; // [RULE_15]
    assign oe_nxt      = !acc_w ? scpr_pkg::OE_OFF :
                         (wb_lvl_w == scpr_pkg::WB_WORD) ? scpr_pkg::OE_WORD
                                                         : scpr_pkg::OE_BYTE; // [RULE_01]

    // Word mode: one read per channel; byte mode: two reads per channel
    assign phase_nxt   = (wb_lvl_w == scpr_pkg::WB_BYTE) ? ~phase_r : 1'b0;   // [RULE_09] [RULE_17]
    assign ptr_nxt     = (phase_nxt) ? ptr_r : next_ch(mask_r, ptr_r);        // [RULE_10]

    // Pointer: completion wins over a read ending in the same cycle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ptr_r   <= scpr_pkg::PTR_RST;
            phase_r <= 1'b0;
            acc_q_r <= 1'b0;
        end
        else if (ce)
        begin
            acc_q_r <= acc_w;
            if (busy_fall_w)
            begin
                ptr_r   <= first_ch(pend_ch_w);                  // [RULE_20]
                phase_r <= 1'b0;
            end
            else if (rd_end_w)
            begin
                ptr_r   <= ptr_nxt;                              // [RULE_20]
                phase_r <= phase_nxt;
            end
        end
    end

    // Output lanes, registered so the pins never glitch
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            db_r <= scpr_pkg::DATA_RST;
            oe_r <= scpr_pkg::OE_OFF;
        end
        else if (ce)
        begin
            db_r <= db_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign db_out    = db_r;
    assign db_oe_n   = oe_r;
    assign busy      = busy_r;
    assign hold_pair = hold_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [scpr_pkg::LEN_W-1:0] act_len_r;

    // Length of the current busy period, saturating
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            act_len_r <= '0;
        else if (ce)
            act_len_r <= !any_act_w ? '0 : (&act_len_r ? act_len_r : act_len_r + 1'b1);
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn || !ce);

    busy_rise_a: assert property ((start_w != 3'h0) |-> ##2 busy_r) // [RULE_18]
        else $error("busy did not rise after start");
    conv_len_a: assert property ($fell(any_act_w) |-> act_len_r >= scpr_pkg::CONV_CYC) // [RULE_03]
        else $error("conversion shorter than its time");
    track_ret_a: assert property (busy_fall_w |=> (hold_r == $past(start_w)) && !busy_r) // [RULE_04]
        else $error("hold not released at busy fall");
    bus_hiz_a: assert property (!acc_w |=> db_oe_n == scpr_pkg::OE_OFF) // [RULE_07]
        else $error("lines driven outside an access");
    word_lane_a: assert property ((acc_w && wb_lvl_w == scpr_pkg::WB_WORD)
        |=> db_oe_n == scpr_pkg::OE_WORD && db_out == $past(cur_w)) // [RULE_01]
        else $error("word read wrong lanes or data");
    byte_lane_a: assert property ((acc_w && wb_lvl_w == scpr_pkg::WB_BYTE && !phase_r)
        |=> db_oe_n == scpr_pkg::OE_BYTE
            && db_out[15:8] == ($past(hbf_lvl_w) ? $past(cur_w[15:8]) : $past(cur_w[7:0]))) // [RULE_16]
        else $error("first byte wrong");
    msb_zero_a: assert property (db_oe_n != scpr_pkg::OE_OFF
        |-> (db_out & ~RES_MASK & {16{db_oe_n == scpr_pkg::OE_WORD}}) == 16'h0000) // [RULE_12]
        else $error("bits above resolution not zero");
    ptr_reset_a: assert property (busy_fall_w |=> ptr_r == first_ch(mask_r) && !phase_r) // [RULE_20]
        else $error("pointer not reset at completion");
    read_order_a: assert property ((rd_end_w && !busy_fall_w && wb_lvl_w == scpr_pkg::WB_WORD)
        |=> ptr_r == next_ch(mask_r, $past(ptr_r))) // [RULE_10]
        else $error("readout order wrong");

    all_six_c: cover property (start_w == 3'h7 ##[1:1000] busy_fall_w);
    word_read_c: cover property (rd_end_w && wb_lvl_w == scpr_pkg::WB_WORD);
    byte_pair_c: cover property (rd_end_w && wb_lvl_w == scpr_pkg::WB_BYTE && phase_r);

endmodule // scpr_top

// File: src/scpr_pkg.sv
// ****************************************************************
// Shared constants for the six-channel parallel readout
// ****************************************************************
package scpr_pkg;

    // Clock rate and conversion time
    localparam int unsigned CLK_MHZ          = 250;
    localparam int unsigned CONV_TIME_US     = 3;                     // conversion_duration
    localparam int unsigned CONV_CYC         = CONV_TIME_US * CLK_MHZ; // 750 cycles
    localparam int unsigned CNT_W            = 10;
    localparam int unsigned LEN_W            = 12;

    // Geometry
    localparam int unsigned NPAIR            = 3;
    localparam int unsigned NCH              = 6;
    localparam int unsigned DW               = 16;
    localparam int unsigned DEF_RES_BITS     = 16;

    // Positions of the pins inside the synchroniser vector
    localparam int unsigned PIN_W            = 8;
    localparam int unsigned PIN_CONV         = 0;
    localparam int unsigned PIN_CS           = 3;
    localparam int unsigned PIN_RD           = 4;
    localparam int unsigned PIN_SPS          = 5;
    localparam int unsigned PIN_WB           = 6;
    localparam int unsigned PIN_HBF          = 7;
    localparam logic [7:0]  PIN_RST          = 8'h1F;  // Strobes idle high
    localparam logic [2:0]  CONV_IDLE        = 3'h7;   // Start pins idle high

    // Mode encodings
    localparam logic        SPS_PARALLEL     = 1'b0;
    localparam logic        WB_WORD          = 1'b0;
    localparam logic        WB_BYTE          = 1'b1;

    // Lane enables, active low: [1] = lines 15..8, [0] = lines 7..0
    localparam logic [1:0]  OE_OFF           = 2'h3;
    localparam logic [1:0]  OE_WORD          = 2'h0;
    localparam logic [1:0]  OE_BYTE          = 2'h1;

    // Reset values
    localparam logic [2:0]  PTR_RST          = 3'h0;
    localparam logic [15:0] DATA_RST         = 16'h0000;

    // Per-pair conversion sequencer
    typedef enum logic {
        PAIR_IDLE = 1'b0,
        PAIR_CONV = 1'b1
    } scpr_pair_st_t;

endpackage

// File: src/scpr_sync.sv
`timescale 1ns/1ps
// ****************************************************************
// Three-stage pin synchroniser with agreement filter
// ****************************************************************
module scpr_sync #(
    parameter int unsigned     W   = 1,
    parameter logic [W-1:0]    RST = '0
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          ce,
    // Pins and filtered levels
    input  wire logic [W-1:0]  pin_in,
    output logic      [W-1:0]  level
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;
    logic [W-1:0] level_nxt;

    // A bit moves only when stages two and three agree; stage one feeds stage two only
    assign level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
    assign level     = level_r;

    // Shift chain
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r    <= RST;
            s2_r    <= RST;
            s3_r    <= RST;
            level_r <= RST;
        end
        else if (ce)
        begin
            s1_r    <= pin_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

endmodule // scpr_sync

// File: src/scpr_pair.sv
`timescale 1ns/1ps
// ****************************************************************
// Conversion timer for one channel pair
// ****************************************************************
module scpr_pair (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic ce,
    // Control
    input  wire logic start,
    output logic      active
);

    scpr_pkg::scpr_pair_st_t        st_r;
    scpr_pkg::scpr_pair_st_t        st_nxt;
    logic [scpr_pkg::CNT_W-1:0]     cnt_r;
    logic [scpr_pkg::CNT_W-1:0]     cnt_nxt;
    logic                           last_w;

    localparam logic [scpr_pkg::CNT_W-1:0] LAST = scpr_pkg::CNT_W'(scpr_pkg::CONV_CYC - 1);

    assign last_w = (cnt_r == LAST);
    assign active = (st_r == scpr_pkg::PAIR_CONV);

    // Starts while converting are ignored so a pair never restarts mid-conversion
    always_comb
    begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        unique case (st_r)
            scpr_pkg::PAIR_IDLE:
            begin
                cnt_nxt = '0;
                if (start)
                    st_nxt = scpr_pkg::PAIR_CONV;
            end
            scpr_pkg::PAIR_CONV:
            begin
                cnt_nxt = cnt_r + 1'b1;
                if (last_w)
                    st_nxt = scpr_pkg::PAIR_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r  <= scpr_pkg::PAIR_IDLE;
            cnt_r <= '0;
        end
        else if (ce)
        begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

endmodule // scpr_pair

// File: dv/scpr_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Host bus controller driving the start pins and the read strobes
// ****************************************************************
module scpr_host (
    // Clock
    input  wire logic       clk_sys,
    // Pins towards the converter
    output logic [2:0]      pair_convert_start,
    output logic            cs_n,
    output logic            rd_n,
    // Status seen from the converter
    input  wire logic       busy,
    input  wire logic [2:0] hold_pair,
    input  wire logic [1:0] db_oe_n
);
    // Strobes idle high, so the first start is a clean low pulse ending in a rising edge
    initial
    begin
        pair_convert_start = 3'h7;
        cs_n               = 1'b1;
        rd_n               = 1'b1;
    end

    // Sample after the edge so the converter's updates have landed
    task automatic tick;
        @(posedge clk_sys);
        #1;
    endtask

    // Pulse the selected start pins, then follow busy to its fall
    task automatic convert(input logic [2:0] mask, output int busy_cyc, output logic [2:0] held);
        int n;
        busy_cyc = 0;
        held = 3'h0;
        for (n = 0; n < 1000 && busy !== 1'b0; n++) tick();
        @(posedge clk_sys);
        pair_convert_start <= ~mask;
        repeat (6) @(posedge clk_sys);
        pair_convert_start <= 3'h7;
        for (n = 0; n < 20 && busy !== 1'b1; n++) tick();
        held = hold_pair;
        for (n = 0; n < 1000 && busy === 1'b1; n++)
        begin
            busy_cyc++;
            tick();
        end
    endtask

    // Open an access; ok tells whether the lines came out of high impedance
    task automatic read_begin(output logic ok);
        int n;
        for (n = 0; n < 1000 && busy !== 1'b0; n++) tick();
        @(posedge clk_sys);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            tick();
            ok = (db_oe_n !== 2'h3);
        end
    endtask

    // Close an access and wait for the lines to be released
    task automatic read_end(output logic ok);
        int n;
        @(posedge clk_sys);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
        ok = 1'b0;
        for (n = 0; n < 20 && !ok; n++)
        begin
            tick();
            ok = (db_oe_n === 2'h3);
        end
    endtask
endmodule // scpr_host

// File: dv/test_six_ch_adc_parallel_readout.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench: three result widths side by side
// ****************************************************************
module test_six_ch_adc_parallel_readout;
    logic             clk_sys;
    logic             rstn;
    logic             ce;
    logic [2:0]       pair_convert_start;
    logic             cs_n;
    logic             rd_n;
    logic             serial_parallel_select;
    logic             word_byte_select;
    logic             high_byte_first;
    logic [5:0][15:0] adc_code;
    logic [15:0]      db_out [3];
    logic [1:0]       db_oe_n [3];
    logic             busy [3];
    logic [2:0]       hold_pair [3];
    int               n_mismatch;
    int               comparisons;
    int               seed;
    int               m;
    logic             ok;

    // Widths 16, 14 and 12 share every input
    for (genvar g = 0; g < 3; g++)
    begin : gen_res
        scpr_top #(.RES_BITS(16 - 2 * g)) i_scpr_top (
            .clk_sys                (clk_sys),
            .rstn                   (rstn),
            .ce                     (ce),
            .pair_convert_start     (pair_convert_start),
            .cs_n                   (cs_n),
            .rd_n                   (rd_n),
            .serial_parallel_select (serial_parallel_select),
            .word_byte_select       (word_byte_select),
            .high_byte_first        (high_byte_first),
            .db_out                 (db_out[g]),
            .db_oe_n                (db_oe_n[g]),
            .adc_code               (adc_code),
            .busy                   (busy[g]),
            .hold_pair              (hold_pair[g])
        );
    end

    scpr_host i_scpr_host (
        .clk_sys            (clk_sys),
        .pair_convert_start (pair_convert_start),
        .cs_n               (cs_n),
        .rd_n               (rd_n),
        .busy               (busy[0]),
        .hold_pair          (hold_pair[0]),
        .db_oe_n            (db_oe_n[0])
    );

    // ****************************************************************
    // Checking and reporting
    // ****************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Reference word: sign bit flipped, masked to width, byte lane picked
    function automatic logic [15:0] model(int code, int r, logic wb, logic hbf, int half);
        int full;
        full = (code ^ (1 << (r - 1))) & ((1 << r) - 1);
        if (wb)
            full = ((half == int'(hbf)) ? (full & 255) : (full >> 8)) << 8;
        return 16'(full);
    endfunction

    // One batch: start, check timing, read every result and one wrap
    task automatic run_batch(input logic [2:0] mask, input logic wb, input logic hbf);
        int busy_cyc, ch, k, g, per, idx;
        int chq[$];
        logic [2:0] held;
        @(posedge clk_sys);
        word_byte_select <= wb;
        high_byte_first <= hbf;
        for (ch = 0; ch < 6; ch++)
            adc_code[ch] <= 16'($random(seed));
        repeat (8) @(posedge clk_sys);
        i_scpr_host.convert(mask, busy_cyc, held);
        check(16'(busy_cyc), 16'(scpr_pkg::CONV_CYC));
        check({13'h0, held}, {13'h0, mask});
        check({13'h0, hold_pair[0]}, 16'h0000);
        if (busy_cyc == 0)
            conclude();
        for (ch = 0; ch < 6; ch++)
            if (mask[ch / 2])
                chq.push_back(ch);
        per = wb ? 2 : 1;
        for (k = 0; k <= chq.size() * per; k++)
        begin
            idx = k % (chq.size() * per);
            i_scpr_host.read_begin(ok);
            check({15'h0, ok}, 16'h0001);
            if (ok !== 1'b1)
                conclude();
            check({14'h0, db_oe_n[0]}, {14'h0, wb ? scpr_pkg::OE_BYTE : scpr_pkg::OE_WORD});
            for (g = 0; g < 3; g++)
                check(db_out[g], model(int'(adc_code[chq[idx / per]]), 16 - 2 * g, wb, hbf, idx % per));
            i_scpr_host.read_end(ok);
            check({15'h0, ok}, 16'h0001);
        end
        $display("batch mask %0h byte %0d order %0d reads %0d done", mask, wb, hbf, k);
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // Cuts a hang short
    initial
    begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        conclude();
    end

    initial
    begin
        seed = 32'h47de;
        n_mismatch = 0;
        comparisons = 0;
        rstn = 1'b0;
        ce = 1'b1;
        serial_parallel_select = 1'b0;
        word_byte_select = 1'b0;
        high_byte_first = 1'b0;
        adc_code = '0;
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Word mode, every pair combination; 7 is all six together
        for (m = 1; m < 8; m++)
            run_batch(m[2:0], 1'b0, 1'b0);
        // Byte mode, both byte orders
        run_batch(3'h7, 1'b1, 1'b0);
        run_batch(3'h7, 1'b1, 1'b1);
        run_batch(3'h2, 1'b1, 1'b1);
        // Serial select high: the lines must stay released
        @(posedge clk_sys);
        serial_parallel_select <= 1'b1;
        repeat (8) @(posedge clk_sys);
        i_scpr_host.read_begin(ok);
        check({15'h0, ok}, 16'h0000);
        check({14'h0, db_oe_n[0]}, {14'h0, scpr_pkg::OE_OFF});
        i_scpr_host.read_end(ok);
        $display("serial select test done");
        conclude();
    end
endmodule // test_six_ch_adc_parallel_readout
